// >>> fush_consts.vh
// register offsets, field positions and reset values of the floppy/serial shadow bank
`ifndef FUSH_CONSTS_VH
`define FUSH_CONSTS_VH

// byte addresses on the wishbone slave
`define FUSH_ADDR_FORCE      4'h0
`define FUSH_ADDR_RATE       4'h4
`define FUSH_ADDR_FIFO       4'h8
`define FUSH_ADDR_RATE_WR    4'hC

// force register fields
`define FUSH_FORCE_D0        0
`define FUSH_FORCE_D1        1

// rate shadow fields
`define FUSH_RATE_LO         0
`define FUSH_RATE_HI         1
`define FUSH_WRITE_SELECT_A_LO      2
`define FUSH_WRITE_SELECT_A_HI      4
`define FUSH_RATE_RSVD       5
`define FUSH_RATE_PDOWN      6
`define FUSH_RATE_SRST       7

// fifo control shadow fields
`define FUSH_FIFO_EN         0
`define FUSH_FIFO_RXCLR      1
`define FUSH_FIFO_TXCLR      2
`define FUSH_FIFO_DMA        3

// reset values and the rate shadow write mask
`define FUSH_FORCE_RESET     2'h0
`define FUSH_RATE_RESET      8'h00
`define FUSH_FIFO_RESET      8'h00
`define FUSH_RATE_WMASK      8'hDF

`endif

// >>> fush_regs.v
// floppy force-disk-change register with rate and serial fifo control shadows
//
// Overview of operation
// - forced bit plus selected drive shows disk-changed active regardless of pin
// - force bit 0 controls drive 0 forced change; 1 active
// - force bit 1 controls drive 1 forced change; 1 active
// - force register bits 7 to 2 always read zero
// - rate shadow returns data-rate bits 0 and 1; bus writes ignored
// - rate shadow returns precompensation select in bits 2 through 4
// - rate shadow bit 5 reserved, bit 6 power-down, bit 7 soft reset
// - rate shadow cleared by main, standby power-on and hard reset
// - fifo shadow: enable bit0, rx clear bit1, tx clear bit2, dma bit3
// - force bit clears when its drive select and step both active
// - disk change flag is or of pin and both forced selected drives
//
// Decided for this implementation: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`include "fush_consts.vh"
module fush_regs (
	input  wire       clk,
	input  wire       rst,
	input  wire       main_power_on_reset,
	input  wire       standby_power_on_reset,
	input  wire       hard_reset,
	// classic wishbone slave
	input  wire       wb_cyc_i,
	input  wire       wb_stb_i,
	input  wire       wb_we_i,
	input  wire [3:0] wb_adr_i,
	input  wire [3:0] wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg        wb_ack_o,
	output reg        wb_err_o,
	// floppy pins, active low
	input  wire       disk_changed_in_n,
	input  wire       drive0_select_n,
	input  wire       drive1_select_n,
	input  wire       head_step_pulse_n,
	// write-only register writes seen from the cores
	input  wire       rate_wr,
	input  wire [7:0] rate_wdata,
	input  wire       fifo_wr,
	input  wire [7:0] fifo_wdata,
	// disk change flag toward the input register
	output reg        disk_change_flag
);
	// ****************************************
	// pin synchronisers
	// ****************************************
	wire dskchg_lvl_n;
	wire ds0_lvl_n;
	wire ds1_lvl_n;
	wire step_lvl_n;

	fush_sync2 u_sync_chg (
		.clk     (clk),
		.rst     (rst),
		.rst_val (1'b1),
		.pin     (disk_changed_in_n),
		.lvl     (dskchg_lvl_n)
	);
	fush_sync2 u_sync_ds0 (
		.clk     (clk),
		.rst     (rst),
		.rst_val (1'b1),
		.pin     (drive0_select_n),
		.lvl     (ds0_lvl_n)
	);
	fush_sync2 u_sync_ds1 (
		.clk     (clk),
		.rst     (rst),
		.rst_val (1'b1),
		.pin     (drive1_select_n),
		.lvl     (ds1_lvl_n)
	);
	fush_sync2 u_sync_stp (
		.clk     (clk),
		.rst     (rst),
		.rst_val (1'b1),
		.pin     (head_step_pulse_n),
		.lvl     (step_lvl_n)
	);

	wire first_drive_sel  = ~ds0_lvl_n;
	wire second_drive_sel = ~ds1_lvl_n;
	wire step_act         = ~step_lvl_n;

	// ****************************************
	// bus decode
	// ****************************************
	wire bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
	wire wr_lane0  = bus_req & wb_we_i & wb_sel_i[0];
	reg  hit_force;
	reg  hit_rate;
	reg  hit_fifo;
	reg  hit_rate_wr;

	// address decode as an if chain
	always @* begin
		hit_force   = 1'b0;
		hit_rate    = 1'b0;
		hit_fifo    = 1'b0;
		hit_rate_wr = 1'b0;
		if (wb_adr_i == `FUSH_ADDR_FORCE) begin
			hit_force = 1'b1;
		end else if (wb_adr_i == `FUSH_ADDR_RATE) begin
			hit_rate = 1'b1;
		end else if (wb_adr_i == `FUSH_ADDR_FIFO) begin
			hit_fifo = 1'b1;
		end else if (wb_adr_i == `FUSH_ADDR_RATE_WR) begin
			hit_rate_wr = 1'b1;
		end
	end

	wire hit_any = hit_force | hit_rate | hit_fifo | hit_rate_wr;

	// ****************************************
	// force disk change register
	// ****************************************
	reg  [1:0] force_reg;
	reg  [1:0] force_next;
	wire       clr0 = first_drive_sel & step_act;
	wire       clr1 = second_drive_sel & step_act;

	// software only sets; the step with select clears, and a clear wins
	// since software has no other way to drop the bit
	always @* begin
		force_next = force_reg;
		if (wr_lane0 && hit_force) begin
			force_next[0] = force_reg[0] | wb_dat_i[`FUSH_FORCE_D0];
			force_next[1] = force_reg[1] | wb_dat_i[`FUSH_FORCE_D1];
		end
		if (clr0) begin
			force_next[0] = 1'b0;
		end
		if (clr1) begin
			force_next[1] = 1'b0;
		end
	end

	always @(posedge clk) begin
		if (rst || main_power_on_reset || hard_reset) begin
			force_reg <= `FUSH_FORCE_RESET;
		end else begin
			force_reg <= force_next;
		end
	end

	// ****************************************
	// disk change flag
	// ****************************************
	// forced term overrides the pin while that drive is selected
	always @(posedge clk) begin
		if (rst) begin
			disk_change_flag <= 1'b0;
		end else begin
			disk_change_flag <= ~dskchg_lvl_n
				| (first_drive_sel & force_reg[0])
				| (second_drive_sel & force_reg[1]);
		end
	end

	// ****************************************
	// shadow registers
	// ****************************************
	wire       shadow_rst = rst | main_power_on_reset | standby_power_on_reset | hard_reset;
	wire [7:0] rate_shadow_reg;
	wire [7:0] fifo_shadow_reg;

	// rate shadow loads only from the core write port; the spare offset
	// is decoded and acknowledged but moves nothing, so bus writes stay inert
	fush_shadow8 u_rate (
		.clk   (clk),
		.rst   (shadow_rst),
		.load  (rate_wr),
		.wmask (`FUSH_RATE_WMASK),
		.din   (rate_wdata),
		.q     (rate_shadow_reg)
	);

	// all eight fifo control bits are kept, upper ones mirror as written
	fush_shadow8 u_fifo (
		.clk   (clk),
		.rst   (shadow_rst),
		.load  (fifo_wr),
		.wmask (8'hFF),
		.din   (fifo_wdata),
		.q     (fifo_shadow_reg)
	);

	// ****************************************
	// read mux and acknowledge
	// ****************************************
	reg [7:0] rd_byte;

	// shadows are read only; writes at their offsets are acknowledged and dropped
	always @* begin
		rd_byte = 8'h00;
		if (hit_force) begin
			rd_byte = {6'h00, force_reg};
		end else if (hit_rate) begin
			rd_byte = rate_shadow_reg;
		end else if (hit_fifo) begin
			rd_byte = fifo_shadow_reg;
		end
	end

	// one wait-free answer: ack or err the edge after the request is seen
	always @(posedge clk) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= bus_req & hit_any;
			wb_err_o <= bus_req & ~hit_any;
			if (bus_req && !wb_we_i) begin
				wb_dat_o <= {24'h000000, rd_byte};
			end
		end
	end
endmodule

// >>> fush_regs_chk.sv
// port checks for the force and shadow register bank
`timescale 1ns/1ps
module fush_chk (
	input logic        clk,
	input logic        rst,
	input logic        main_power_on_reset,
	input logic        hard_reset,
	input logic        wb_cyc_i,
	input logic        wb_stb_i,
	input logic        wb_we_i,
	input logic [3:0]  wb_adr_i,
	input logic [3:0]  wb_sel_i,
	input logic [31:0] wb_dat_i,
	input logic [31:0] wb_dat_o,
	input logic        wb_ack_o,
	input logic        wb_err_o,
	input logic        disk_changed_in_n,
	input logic        drive0_select_n,
	input logic        drive1_select_n,
	input logic        head_step_pulse_n,
	input logic        disk_change_flag
);
	// ****
	// assertions
	// ****
	default clocking cb @(posedge clk); endclocking
	// main power-on and hard reset clear the force bits too, so they mask every check
	default disable iff (rst || main_power_on_reset || hard_reset);
	// new request, read answer, force bit 0 written, no other influence on drive 0
	wire take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	wire rd = wb_ack_o && !wb_we_i;
	wire set0 = wb_ack_o && wb_we_i && wb_adr_i == 4'h0 && wb_sel_i[0] && wb_dat_i[0];
	wire quiet = disk_changed_in_n && drive1_select_n && !wb_stb_i;

	a_answer_next: assert property (take |=> wb_ack_o != wb_err_o)
		else $error("request not answered");
	a_err_unmapped: assert property (take && wb_adr_i[1:0] != 2'h0 |=> wb_err_o)
		else $error("no err on unmapped");
	a_force_rsvd: assert property (rd && wb_adr_i == 4'h0 |-> wb_dat_o[31:2] == 30'h0)
		else $error("force upper bits set");
	a_rate_rsvd: assert property (rd && wb_adr_i == 4'h4 |-> !wb_dat_o[5])
		else $error("rate bit 5 set");
	a_flag_pin: assert property (!disk_changed_in_n [*3] |=> disk_change_flag)
		else $error("flag misses pin");
	a_flag_idle: assert property (
		(disk_changed_in_n && drive0_select_n && drive1_select_n) [*3] |=> !disk_change_flag)
		else $error("flag without cause");
	a_force_sets: assert property (
		head_step_pulse_n [*5] ##0 set0 ##1 (!drive0_select_n && head_step_pulse_n) [*3] |=> disk_change_flag)
		else $error("forced change not shown");
	a_step_clears: assert property (
		(!drive0_select_n && !head_step_pulse_n && quiet) [*3] ##1
		(!drive0_select_n && head_step_pulse_n && quiet) [*4] |=> !disk_change_flag)
		else $error("force not cleared by step");
	c_rate_read: cover property (rd && wb_adr_i == 4'h4);
	c_err_seen: cover property (wb_err_o);
	c_forced: cover property (disk_change_flag && disk_changed_in_n);
endmodule

// >>> fush_shadow8.v
// eight-bit shadow of a write-only register, loaded on each write strobe
`timescale 1ns/1ps
module fush_shadow8 (
	input  wire       clk,
	input  wire       rst,
	input  wire       load,
	input  wire [7:0] wmask,
	input  wire [7:0] din,
	output reg  [7:0] q
);
	// masked bits stay zero so reserved positions never hold data
	always @(posedge clk) begin
		if (rst) begin
			q <= 8'h00;
		end else if (load) begin
			q <= din & wmask;
		end
	end
endmodule

// >>> fush_sync2.v
// two-flop synchroniser for one pin level
`timescale 1ns/1ps
module fush_sync2 (
	input  wire clk,
	input  wire rst,
	input  wire rst_val,
	input  wire pin,
	output reg  lvl
);
	reg meta_reg;

	// first stage feeds only the second; reset value comes from a tie, so it is a constant per instance
	always @(posedge clk) begin
		if (rst) begin
			meta_reg <= rst_val;
			lvl      <= rst_val;
		end else begin
			meta_reg <= pin;
			lvl      <= meta_reg;
		end
	end
endmodule

// >>> test_floppy_uart_shadow_regs.sv
// random and corner stimulus for the force and shadow bank
`timescale 1ns/1ps
`include "fush_consts.vh"
`define CHK(g, x) begin compares++; if ((g) !== (x)) begin fails++; $display("MISMATCH %0t %h %h", $time, g, x); end end
module test_floppy_uart_shadow_regs;
	reg         clk = 1'h0, rst = 1'h1, main_power_on_reset = 1'h0, standby_power_on_reset = 1'h0, hard_reset = 1'h0;
	reg         wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0, rate_wr = 1'h0, fifo_wr = 1'h0, e;
	reg  [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'h0;
	reg  [31:0] wb_dat_i = 32'h0, q;
	reg  [7:0]  rate_wdata = 8'h00, fifo_wdata = 8'h00, rate_m = 8'h00, fifo_m = 8'h00, d;
	reg         disk_changed_in_n = 1'h1, drive0_select_n = 1'h1, drive1_select_n = 1'h1, head_step_pulse_n = 1'h1;
	wire [31:0] wb_dat_o;
	wire        wb_ack_o, wb_err_o, disk_change_flag;
	integer     fails = 0, compares = 0, i, n;

	// ****
	// helpers
	// ****
	always #50 clk = ~clk;
	fush_regs uut (.*);
	// reserved bit 5 of the rate shadow reads as zero
	function [7:0] rate_exp(input [7:0] v);
		rate_exp = v & 8'hDF;
	endfunction
	task summarize;
		if (fails == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// one classic cycle; the bounded wait guards against a dead slave
	task wb(input [3:0] a, input w, input [7:0] v, input [3:0] s);
		@(posedge clk);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'h3, w, a, s, 24'h000000, v};
		n = 0;
		@(posedge clk);
		while (!(wb_ack_o || wb_err_o) && n < 20) begin
			n = n + 1;
			@(posedge clk);
		end
		q = wb_dat_o;
		e = wb_err_o;
		{wb_cyc_i, wb_stb_i} <= 2'h0;
		if (n >= 20) begin
			fails++;
			summarize;
		end
	endtask
	task rd(input [3:0] a, input [7:0] x);
		wb(a, 1'h0, 8'h00, 4'hF);
		`CHK(q, x)
	endtask
	task shw(input r, input [7:0] v);
		@(posedge clk);
		{rate_wr, fifo_wr, rate_wdata, fifo_wdata} <= {r, !r, v, v};
		@(posedge clk);
		{rate_wr, fifo_wr} <= 2'h0;
	endtask
	// pins as {disk, drive0, drive1, step}; four edges cover sync plus register
	task pins(input [3:0] p);
		{disk_changed_in_n, drive0_select_n, drive1_select_n, head_step_pulse_n} <= p;
		repeat (4) @(posedge clk);
	endtask
	task rstp(input [2:0] w);
		{main_power_on_reset, standby_power_on_reset, hard_reset} <= w;
		@(posedge clk);
		{main_power_on_reset, standby_power_on_reset, hard_reset} <= 3'h0;
	endtask

	// ****
	// main sequence
	// ****
	initial begin
		d = $urandom(72);
		repeat (10) @(posedge clk);
		rst <= 1'h0;
		for (i = 0; i < 16; i = i + 4)
			rd(i[3:0], 8'h00);
		// shadows follow core writes, ignore bus writes; zero and all-ones first
		for (i = 0; i < 24; i = i + 1) begin
			d = (i < 2) ? {8{i[0]}} : $urandom;
			shw(i[0], d);
			if (i[0])
				rate_m = rate_exp(d);
			else
				fifo_m = d;
			wb(i[0] ? `FUSH_ADDR_RATE : `FUSH_ADDR_FIFO, 1'h1, ~d, 4'hF);
			rd(`FUSH_ADDR_RATE, rate_m);
			rd(`FUSH_ADDR_FIFO, fifo_m);
			wb({d[3:1], d[0] | ~d[1]}, d[4], ~d, 4'hF);
			`CHK(e, 1'h1)
		end
		wb(`FUSH_ADDR_FORCE, 1'h1, 8'hFF, 4'hE);
		rd(`FUSH_ADDR_FORCE, 8'h00);
		wb(`FUSH_ADDR_FORCE, 1'h1, 8'hFD, 4'h1);
		pins(4'hB);
		`CHK(disk_change_flag, 1'h1)
		rd(`FUSH_ADDR_FORCE, 8'h01);
		wb(`FUSH_ADDR_FORCE, 1'h1, 8'h02, 4'h1);
		wb(`FUSH_ADDR_FORCE, 1'h1, 8'h00, 4'h1);
		rd(`FUSH_ADDR_FORCE, 8'h03);
		pins(4'hA);
		pins(4'hB);
		`CHK(disk_change_flag, 1'h0)
		rd(`FUSH_ADDR_FORCE, 8'h02);
		pins(4'hD);
		`CHK(disk_change_flag, 1'h1)
		pins(4'hC);
		pins(4'hF);
		rd(`FUSH_ADDR_FORCE, 8'h00);
		pins(4'h7);
		`CHK(disk_change_flag, 1'h1)
		// hard, standby, main: standby leaves the force bits alone
		for (i = 0; i < 3; i = i + 1) begin
			shw(1'h1, 8'hFF);
			shw(1'h0, 8'hFF);
			wb(`FUSH_ADDR_FORCE, 1'h1, 8'h03, 4'h1);
			rstp(3'h1 << i);
			rd(`FUSH_ADDR_RATE, 8'h00);
			rd(`FUSH_ADDR_FIFO, 8'h00);
			rd(`FUSH_ADDR_FORCE, (i == 1) ? 8'h03 : 8'h00);
		end
		summarize;
	end
endmodule
bind fush_regs fush_chk chk (.*);
